/* File: verilog/fast_xfer_pkg.sv */
// What this block does
// - fast iso enable routes every iso fifo register access over external data bus
// - fast read of iso out fifo drives byte out and pulses write strobe
// - fast write to iso fifo ignores accumulator, loads bus byte with read strobe
// - read mode bits 4:3 and write mode bits 1:0 pick strobe timing
// - polarity bits 5 and 2: zero active low, one active high
// - bit 7 enables fast iso, bit 6 fast bulk, independently
// - sixteen bit auto pointer; each auto data access moves a byte and advances it
// - each fast transfer moves one byte inside one two-cycle move
// - machine cycle is four core clocks; strobe timing counts in core clocks, eight per move
// - iso start address register bits 7:2 carry address bits 9:4
package fast_xfer_pkg;
   localparam logic [15:0] fast_transfer_control_addr = 16'h7fe2;
   localparam logic [15:0] auto_pointer_hi_addr = 16'h7fe3;
   localparam logic [15:0] auto_pointer_lo_addr = 16'h7fe4;
   localparam logic [15:0] auto_pointer_data_addr = 16'h7fe5;
   localparam logic [15:0] iso_fifo_base_addr = 16'h7f60;
   localparam logic [15:0] iso_addr_base_addr = 16'h7ff0;
   localparam logic [7:0] fast_transfer_control_reset = 8'h00;
   localparam int fast_iso_enable_bit = 7;
   localparam int fast_bulk_enable_bit = 6;
   localparam int read_strobe_polarity_bit = 5;
   localparam int rmod_lsb = 3;
   localparam int write_strobe_polarity_bit = 2;
   localparam int wmod_lsb = 0;
   localparam int clocks_per_cycle = 4;
   localparam int move_cycles = 2;
   localparam int move_clocks = clocks_per_cycle * move_cycles;
   localparam int ram_depth = 1024;
endpackage

/* File: verilog/strobe_if.sv */
`timescale 1ns/1ps
interface strobe_if;
   logic start;
   logic [1:0] mode;
   logic pol;
   logic level;
   logic sample;
   modport ctl (output start, output mode, output pol, input level, input sample);
   modport gen (input start, input mode, input pol, output level, output sample);
endinterface

/* File: verilog/strobe_gen.sv */
`timescale 1ns/1ps
module strobe_gen
   import fast_xfer_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   strobe_if.gen s
);
   typedef struct packed {
      logic busy;
      logic [2:0] cnt;
      logic [1:0] mode;
      logic pol;
   } st_s;
   st_s q, d;
   logic act;
   // pulse window within the eight-clock move, picked by mode
   always_comb begin
      d = q;
      act = 1'b0;
      if (q.busy) begin
         case (q.mode)
            2'b00: act = (q.cnt == 3'd4);
            2'b01: act = (q.cnt == 3'd3);
            2'b10: act = (q.cnt >= 3'd2) && (q.cnt <= 3'd5);
            default: act = (q.cnt >= 3'd3) && (q.cnt <= 3'd5);
         endcase
         d.cnt = q.cnt + 3'd1;
         if (q.cnt == 3'(move_clocks - 1)) begin
            d.busy = 1'b0;
         end
      end
      // a request in the last clock of a move is taken, so back to back moves lose no strobe
      if (s.start && (!q.busy || q.cnt == 3'(move_clocks - 1))) begin
         d.busy = 1'b1;
         d.cnt = 3'd0;
         d.mode = s.mode;
         d.pol = s.pol;
      end
   end
   // idle level follows the live polarity bit, so a polarity change shows before any move
   assign s.level = q.busy ? (act ? q.pol : ~q.pol) : ~s.pol;
   assign s.sample = q.busy && (q.cnt == 3'd5);
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule // strobe_gen

/* File: verilog/fast_xfer.sv */
`timescale 1ns/1ps
module fast_xfer
   import fast_xfer_pkg::*;
#(
   parameter int ram_words = 1024
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   input wire logic [7:0] ext_data_in,
   output logic [7:0] ext_data_out,
   output logic ext_data_oe,
   output logic fast_read_strobe_n,
   output logic fast_write_strobe_n,
   output logic busy
);
   import fast_xfer_pkg::*;
   if (ram_words != ram_depth) begin : g_bad_depth
      $error("ram_words must be 1024");
   end
   typedef struct packed {
      logic [7:0] ctl;
      logic [15:0] aptr;
      logic [7:0] rdata;
      logic [7:0] dout;
      logic oe;
      logic rd_pend;
      logic [9:0] waddr;
      logic [3:0] wait_cnt;
   } st_s;
   st_s q, d;
   logic [7:0] ram [0:ram_words-1];
   logic [7:0] start_addr [0:15];
   logic [9:0] fifo_ptr [0:15];
   strobe_if rs();
   strobe_if ws();
   strobe_gen u_rd (.mclk(mclk), .rst_b(rst_b), .s(rs));
   strobe_gen u_wr (.mclk(mclk), .rst_b(rst_b), .s(ws));
   logic is_fifo, is_auto, fast, acc;
   logic [3:0] ep;
   logic [9:0] addr;
   logic ram_we;
   logic [7:0] ram_wd;
   always_comb begin
      d = q;
      is_fifo = (cpu_addr[15:4] == iso_fifo_base_addr[15:4]);
      is_auto = (cpu_addr == auto_pointer_data_addr);
      ep = cpu_addr[3:0];
      fast = (is_fifo && q.ctl[fast_iso_enable_bit]) || (is_auto && q.ctl[fast_bulk_enable_bit]);
      acc = (cpu_rd || cpu_wr) && q.wait_cnt == 4'd0;
      addr = is_auto ? q.aptr[9:0] : fifo_ptr[ep];
      ram_we = 1'b0;
      ram_wd = cpu_wdata;
      rs.start = 1'b0;
      ws.start = 1'b0;
      rs.mode = q.ctl[rmod_lsb +: 2];
      ws.mode = q.ctl[wmod_lsb +: 2];
      rs.pol = q.ctl[read_strobe_polarity_bit];
      ws.pol = q.ctl[write_strobe_polarity_bit];
      if (q.wait_cnt != 4'd0) begin
         d.wait_cnt = q.wait_cnt - 4'd1;
      end else begin
         d.oe = 1'b0;
      end
      if (rs.sample && q.rd_pend) begin
         ram_we = 1'b1;
         ram_wd = ext_data_in;
         d.rd_pend = 1'b0;
      end else if (acc && cpu_wr && !fast && (is_fifo || is_auto)) begin
         ram_we = 1'b1;
      end
      if (acc && cpu_wr) begin
         if (cpu_addr == fast_transfer_control_addr) d.ctl = cpu_wdata;
         if (cpu_addr == auto_pointer_hi_addr) d.aptr[15:8] = cpu_wdata;
         if (cpu_addr == auto_pointer_lo_addr) d.aptr[7:0] = cpu_wdata;
      end
      if (acc && (is_fifo || is_auto)) begin
         if (is_auto) d.aptr = q.aptr + 16'd1;
         if (fast) begin
            d.wait_cnt = 4'(move_clocks - 1);
            if (cpu_rd) begin
               d.dout = ram[addr];
               d.oe = 1'b1;
               ws.start = 1'b1;
            end else begin
               d.rd_pend = 1'b1;
               d.waddr = addr;
               rs.start = 1'b1;
            end
         end
      end
      if (acc && cpu_rd) begin
         if (is_fifo || is_auto) d.rdata = ram[addr];
         else if (cpu_addr == fast_transfer_control_addr) d.rdata = q.ctl;
         else if (cpu_addr == auto_pointer_hi_addr) d.rdata = q.aptr[15:8];
         else if (cpu_addr == auto_pointer_lo_addr) d.rdata = q.aptr[7:0];
         else if (cpu_addr[15:4] == iso_addr_base_addr[15:4]) d.rdata = start_addr[ep];
         else d.rdata = 8'h00;
      end
   end
   assign cpu_rdata = q.rdata;
   assign ext_data_out = q.dout;
   assign ext_data_oe = q.oe;
   assign fast_read_strobe_n = rs.level;
   assign fast_write_strobe_n = ws.level;
   assign busy = q.wait_cnt != 4'd0;
   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         q <= '0;
         q.ctl <= fast_transfer_control_reset;
      end else begin
         q <= d;
      end
   end
   // memories kept outside the state struct; no reset on ram contents
   always_ff @(posedge mclk) begin
      if (ram_we) ram[rs.sample && q.rd_pend ? q.waddr : addr] <= ram_wd;
   end
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 16; i++) begin
         if (!rst_b) begin
            start_addr[i] <= 8'h00;
            fifo_ptr[i] <= 10'h000;
         end else if (acc && cpu_wr && cpu_addr == (iso_addr_base_addr | 16'(i))) begin
            start_addr[i] <= {cpu_wdata[7:2], 2'b00};
            fifo_ptr[i] <= {cpu_wdata[7:2], 4'h0};
         end else if (acc && is_fifo && ep == 4'(i)) begin
            fifo_ptr[i] <= fifo_ptr[i] + 10'd1;
         end
      end
   end
endmodule // fast_xfer

/* File: dv/fast_xfer_chk.sv */
`timescale 1ns/1ps
module fast_xfer_chk
   import fast_xfer_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic ext_data_oe,
   input wire logic fast_read_strobe_n,
   input wire logic fast_write_strobe_n,
   input wire logic busy
);
   // shadow of the control register: mode and polarity are not visible at the ports
   logic [7:0] c_q;
   logic go;
   logic fi;
   assign go = (cpu_rd | cpu_wr) & !busy;
   assign fi = go & c_q[fast_iso_enable_bit] & (cpu_addr[15:4] == 12'h7f6);
   always_ff @(posedge mclk)
      if (!rst_b)
         c_q <= 8'h00;
      else if (go & cpu_wr & (cpu_addr == fast_transfer_control_addr))
         c_q <= cpu_wdata;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_ro; fi & cpu_rd & !cpu_addr[3] |=> busy & ext_data_oe; endproperty
   a_ro: assert property (p_ro) else $error("fast out read");
   property p_wi; fi & cpu_wr & cpu_addr[3] |=> busy & !ext_data_oe; endproperty
   a_wi: assert property (p_wi) else $error("fast in write");
   property p_bk; go & c_q[fast_bulk_enable_bit] & (cpu_addr == auto_pointer_data_addr) |=> busy; endproperty
   a_bk: assert property (p_bk) else $error("fast bulk");
   property p_off; go & !(|c_q[7:6]) |=> !busy; endproperty
   a_off: assert property (p_off) else $error("slow access");
   property p_len; $rose(busy) |-> busy[*6] ##[1:2] !busy; endproperty
   a_len: assert property (p_len) else $error("move length");
   property p_wm; $rose(ext_data_oe) & !(|c_q[1:0]) |-> ##4 fast_write_strobe_n == c_q[2];
   endproperty
   a_wm: assert property (p_wm) else $error("write strobe");
   property p_rm; $rose(busy) & !ext_data_oe & !(|c_q[4:3]) |-> ##4 fast_read_strobe_n == c_q[5];
   endproperty
   a_rm: assert property (p_rm) else $error("read strobe");
   property p_idl; !busy & !go & $stable(c_q) |=> fast_write_strobe_n == !c_q[2]; endproperty
   a_idl: assert property (p_idl) else $error("idle level");
endmodule // fast_xfer_chk
bind fast_xfer fast_xfer_chk chk (.mclk, .rst_b, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata,
   .ext_data_oe, .fast_read_strobe_n, .fast_write_strobe_n, .busy);

/* File: dv/ext_fifo_model.sv */
`timescale 1ns/1ps
module ext_fifo_model (
   input wire logic mclk,
   input wire logic busy,
   input wire logic write_strobe_polarity,
   input wire logic [7:0] nxt,
   input wire logic [7:0] ext_data_out,
   input wire logic ext_data_oe,
   input wire logic fast_write_strobe_n,
   output logic [7:0] ext_data_in,
   output logic [7:0] got
);
   // bus shows the inverse byte while the device drives, so a stale value cannot pass
   assign ext_data_in = ext_data_oe ? ~nxt : nxt;
   // write strobe pin taken as enabled at the level on the polarity port
   always @(posedge mclk)
      if (busy && fast_write_strobe_n == write_strobe_polarity)
         got <= ext_data_out;
endmodule // ext_fifo_model

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import fast_xfer_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, cpu_rd = 1'b0, cpu_wr = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic [7:0] cpu_wdata = 8'h00, ctl = 8'h00, nxt = 8'h00;
   logic [7:0] cpu_rdata, ext_data_in, ext_data_out, got;
   logic ext_data_oe, fast_read_strobe_n, fast_write_strobe_n, busy;
   int err_count = 0, samples_checked = 0, cyc = 0;
   always #5 mclk = ~mclk;
   fast_xfer DUT (.mclk, .rst_b, .cpu_rd, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata,
      .ext_data_in, .ext_data_out, .ext_data_oe, .fast_read_strobe_n, .fast_write_strobe_n,
      .busy);
   ext_fifo_model far (.mclk, .busy, .write_strobe_polarity(ctl[2]), .nxt, .ext_data_out, .ext_data_oe,
      .fast_write_strobe_n, .ext_data_in, .got);
   task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic acc(logic w, logic [15:0] a, logic [7:0] d);
      @(negedge mclk);
      {cpu_rd, cpu_wr, cpu_addr, cpu_wdata} = {!w, w, a, d};
      @(negedge mclk);
      {cpu_rd, cpu_wr} = 2'b00;
      // a stuck busy is caught by the cycle ceiling
      while (busy !== 1'b0) @(negedge mclk);
      if (w && a == fast_transfer_control_addr)
         ctl = d;
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      acc(1'b0, fast_transfer_control_addr, 8'h00);
      chk("ctl_rst", cpu_rdata, fast_transfer_control_reset);
      acc(1'b1, iso_addr_base_addr, 8'h00);
      acc(1'b1, iso_fifo_base_addr, 8'h5a);
      acc(1'b1, iso_addr_base_addr + 16'h0008, 8'h07);
      acc(1'b0, iso_addr_base_addr + 16'h0008, 8'h00);
      chk("start_addr", cpu_rdata, 8'h04);
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, fast_transfer_control_addr, 8'h80 + 8'(9 * m + 4 * (m % 2) + 32 * (m / 2)));
         acc(1'b1, iso_addr_base_addr, 8'h00);
         acc(1'b0, iso_fifo_base_addr, 8'h00);
         chk("ext_out", got, 8'h5a);
         nxt = 8'h30 + 8'(m);
         acc(1'b1, 16'h7f68, 8'hff);
      end
      acc(1'b1, fast_transfer_control_addr, 8'h40);
      acc(1'b1, auto_pointer_hi_addr, 8'h00);
      acc(1'b1, auto_pointer_lo_addr, 8'h80);
      for (int k = 0; k < 2; k++) begin
         nxt = 8'ha5 + 8'(k);
         acc(1'b1, auto_pointer_data_addr, 8'h00);
      end
      acc(1'b1, fast_transfer_control_addr, 8'h00);
      acc(1'b1, auto_pointer_lo_addr, 8'h80);
      for (int k = 0; k < 2; k++) begin
         acc(1'b0, auto_pointer_data_addr, 8'h00);
         chk("auto", cpu_rdata, 8'ha5 + 8'(k));
      end
      acc(1'b1, iso_addr_base_addr + 16'h0008, 8'h04);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 16'h7f68, 8'h00);
         chk("in_fifo", cpu_rdata, 8'h30 + 8'(i));
      end
      acc(1'b0, 16'h7e00, 8'h00);
      chk("unmapped", cpu_rdata, 8'h00);
      conclude();
   end
endmodule // testbench
